/* File: rtl/pcbd_divider.sv */
// divide-by-two and divide-by-four references on the oscillator clock
module pcbd_divider
   import pcbd_pkg::*;
(
   input  wire logic oscClk,
   input  wire logic rstN,
   input  wire logic clearN,
   output logic      halfRate,
   output logic      quarterRate
);
   logic [1:0] countReg;
   logic       clearPrevReg;
   wire        clearFall = clearPrevReg & ~clearN;
   always_ff @(posedge oscClk or negedge rstN) begin
      if (!rstN) begin
         countReg     <= DIV_RESET;
         clearPrevReg <= 1'b1;
      end else begin
         clearPrevReg <= clearN;
         if (clearFall) begin
            countReg <= DIV_RESET; // R05 R15
         end else begin
            countReg <= countReg + 2'h1; // R01
         end
      end
   end
   // both taps are flip-flop bits, so duty is exactly half
   assign halfRate    = countReg[0]; // R11
   assign quarterRate = countReg[1]; // R11
endmodule

/* File: rtl/pcbd_pkg.sv */
// package of constants for the pll clock bank divider
// Notes on behaviour
// R01: the oscillator is divided by two and by four, each at 50 percent duty.
// R02: the select bits pick half or quarter rate for banks one to three.
// R03: on quarter rate: 00 none, 01 bank 1, 10 banks 1 and 2, 11 banks 1 to 3.
// R04: while the active-low output enable is high every output is held low.
// R05: a falling edge of the clear input resets the half-rate outputs.
// R06: the test input bypasses the loop; systems tie it low in normal use.
// R07: after any configuration change the system waits before relying on lock.
// R08: one output is fed back and the loop matches its rate to the reference.
// R09: feeding back a half-rate output needs a 50 to 100 MHz reference.
// R10: feeding back a quarter-rate output needs a 25 to 50 MHz reference.
// R11: every output has 50 percent duty whatever the reference duty.
// R12: outputs at the reference rate switch in phase with the reference.
// R13: bank four always carries the half-rate reference.
// R14: test low runs outputs through the loop, test high bypasses it.
// R15: the clear also restarts the quarter-rate divider in a known phase.
package pcbd_pkg;
   localparam int          BANK_COUNT     = 4;
   localparam int          BANK_WIDTH     = 3;
   localparam int          SEL_WIDTH      = 2;
   localparam logic [1:0]  DIV_RESET      = 2'h0;
   localparam logic        LEVEL_RESET    = 1'h0;
   localparam int          STATUS_OFFSET  = 32'h0000_0000;
   localparam int          CONFIG_OFFSET  = 32'h0000_0004;
   localparam int          CFG_SEL_LSB    = 0;
   localparam int          CFG_OE_BIT     = 2;
   localparam int          CFG_TEST_BIT   = 3;
   localparam int          CFG_CLEAR_BIT  = 4;
   localparam logic [31:0] CONFIG_RESET   = 32'h0000_0014;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam int          REF_MIN_A_MHZ  = 50;
   localparam int          REF_MAX_A_MHZ  = 100;
   localparam int          REF_MIN_B_MHZ  = 25;
   localparam int          REF_MAX_B_MHZ  = 50;
endpackage

/* File: rtl/pcbd_sync.sv */
// two flip-flop level synchroniser
module pcbd_sync
   import pcbd_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstN,
   input  wire logic din,
   output logic      dout
);
   logic stage1Reg;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stage1Reg <= LEVEL_RESET;
         dout      <= LEVEL_RESET;
      end else begin
         stage1Reg <= din;
         dout      <= stage1Reg;
      end
   end
endmodule

/* File: rtl/pcbd_top.sv */
// clock bank divider top with axi4-lite configuration registers
module pcbd_top
   import pcbd_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   input  wire logic                  oscClk,
   input  wire logic                  diffReferenceClock,
   input  wire logic                  loopFeedbackInput,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [31:0]           s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic [BANK_WIDTH-1:0]      bankOneOutputs,
   output logic [BANK_WIDTH-1:0]      bankTwoOutputs,
   output logic [BANK_WIDTH-1:0]      bankThreeOutputs,
   output logic [BANK_WIDTH-1:0]      bankFourOutputs,
   output logic                       pllBypass
);
   logic [31:0] configReg;
   logic        awHeldReg;
   logic        wHeldReg;
   logic [31:0] awAddrReg;
   logic [31:0] wDataReg;
   logic [3:0]  wStrbReg;
   logic        bValidReg;
   logic [1:0]  bRespReg;
   logic        rValidReg;
   logic [31:0] rDataReg;
   logic [1:0]  rRespReg;

   // ---------------- axi4-lite slave on mclk
   wire awTake   = s_axi_awvalid & ~awHeldReg & ~bValidReg;
   wire wTake    = s_axi_wvalid & ~wHeldReg & ~bValidReg;
   wire wrDo     = awHeldReg & wHeldReg & ~bValidReg;
   wire wrCfgHit = awAddrReg[31:2] == CONFIG_OFFSET[31:2];
   wire wrStHit  = awAddrReg[31:2] == STATUS_OFFSET[31:2];
   wire arTake   = s_axi_arvalid & ~rValidReg;
   wire rdCfgHit = s_axi_araddr[31:2] == CONFIG_OFFSET[31:2];
   wire rdStHit  = s_axi_araddr[31:2] == STATUS_OFFSET[31:2];
   wire [31:0] strbMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}},
                           {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};
   wire [31:0] cfgMerged = (configReg & ~strbMask) | (wDataReg & strbMask);

   assign s_axi_awready = ~awHeldReg & ~bValidReg;
   assign s_axi_wready  = ~wHeldReg & ~bValidReg;
   assign s_axi_arready = ~rValidReg;
   assign s_axi_bvalid  = bValidReg;
   assign s_axi_bresp   = bRespReg;
   assign s_axi_rvalid  = rValidReg;
   assign s_axi_rdata   = rDataReg;
   assign s_axi_rresp   = rRespReg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         awHeldReg <= 1'b0;
         wHeldReg  <= 1'b0;
         awAddrReg <= 32'h0000_0000;
         wDataReg  <= 32'h0000_0000;
         wStrbReg  <= 4'h0;
      end else begin
         if (awTake) begin
            awHeldReg <= 1'b1;
            awAddrReg <= s_axi_awaddr;
         end else if (wrDo) begin
            awHeldReg <= 1'b0;
         end
         if (wTake) begin
            wHeldReg <= 1'b1;
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
         end else if (wrDo) begin
            wHeldReg <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         configReg <= CONFIG_RESET;
         bValidReg <= 1'b0;
         bRespReg  <= RESP_OKAY;
      end else begin
         if (wrDo) begin
            bValidReg <= 1'b1;
            bRespReg  <= (wrCfgHit | wrStHit) ? RESP_OKAY : RESP_SLVERR;
            if (wrCfgHit) begin
               configReg <= cfgMerged & 32'h0000_001F;
            end
         end else if (s_axi_bready) begin
            bValidReg <= 1'b0;
         end
      end
   end

   // ---------------- crossings from oscillator and reference clock domains for status
   logic halfRate;
   logic quarterRate;
   logic halfSeen;
   logic quarterSeen;
   logic refSeen;
   logic fbSeen;

   pcbd_sync u_syncHalf (
      .clk  (mclk),
      .rstN (resetn),
      .din  (halfRate),
      .dout (halfSeen)
   );
   pcbd_sync u_syncQuarter (
      .clk  (mclk),
      .rstN (resetn),
      .din  (quarterRate),
      .dout (quarterSeen)
   );
   pcbd_sync u_syncRef ( // R09 R10 R12
      .clk  (mclk),
      .rstN (resetn),
      .din  (diffReferenceClock),
      .dout (refSeen)
   );
   pcbd_sync u_syncFb ( // R08
      .clk  (mclk),
      .rstN (resetn),
      .din  (loopFeedbackInput),
      .dout (fbSeen)
   );

   wire [31:0] statusWord = {28'h000_0000, fbSeen, refSeen,
                             quarterSeen, halfSeen};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rValidReg <= 1'b0;
         rDataReg  <= 32'h0000_0000;
         rRespReg  <= RESP_OKAY;
      end else begin
         if (arTake) begin
            rValidReg <= 1'b1;
            rDataReg  <= rdCfgHit ? configReg :
                         (rdStHit ? statusWord : 32'h0000_0000);
            rRespReg  <= (rdCfgHit | rdStHit) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rValidReg <= 1'b0;
         end
      end
   end

   // ---------------- config bits into the oscillator domain
   logic [SEL_WIDTH-1:0] selOsc;
   // oe and clear cross inverted: sync reset reads as disabled and idle
   logic                 oeOsc;
   logic                 testOsc;
   logic                 clearOsc;
   wire                  clearNOsc = ~clearOsc;

   genvar gi;
   generate
      for (gi = 0; gi < SEL_WIDTH; gi++) begin : g_selSync
         pcbd_sync u_syncSel (
            .clk  (oscClk),
            .rstN (resetn),
            .din  (configReg[CFG_SEL_LSB+gi]),
            .dout (selOsc[gi])
         );
      end
   endgenerate
   pcbd_sync u_syncOe (
      .clk  (oscClk),
      .rstN (resetn),
      .din  (~configReg[CFG_OE_BIT]),
      .dout (oeOsc)
   );
   pcbd_sync u_syncTest (
      .clk  (oscClk),
      .rstN (resetn),
      .din  (configReg[CFG_TEST_BIT]),
      .dout (testOsc)
   );
   pcbd_sync u_syncClear (
      .clk  (oscClk),
      .rstN (resetn),
      .din  (~configReg[CFG_CLEAR_BIT]),
      .dout (clearOsc)
   );

   pcbd_divider u_divider (
      .oscClk      (oscClk),
      .rstN        (resetn),
      .clearN      (clearNOsc),
      .halfRate    (halfRate),
      .quarterRate (quarterRate)
   );

   // ---------------- bank steering in the oscillator domain
   // thermometer code: bank k takes quarter rate when select is at least k
   wire bankOneQuarter   = selOsc >= 2'h1; // R02 R03
   wire bankTwoQuarter   = selOsc >= 2'h2; // R03
   wire bankThreeQuarter = selOsc == 2'h3; // R03
   wire bankOneNext   = bankOneQuarter   ? quarterRate : halfRate;
   wire bankTwoNext   = bankTwoQuarter   ? quarterRate : halfRate;
   wire bankThreeNext = bankThreeQuarter ? quarterRate : halfRate;
   wire bankFourNext  = halfRate; // R13

   always_ff @(posedge oscClk or negedge resetn) begin
      if (!resetn) begin
         bankOneOutputs   <= '0;
         bankTwoOutputs   <= '0;
         bankThreeOutputs <= '0;
         bankFourOutputs  <= '0;
         pllBypass        <= 1'b0;
      end else begin
         // one shared stage keeps every bank aligned with the others
         bankOneOutputs   <= {BANK_WIDTH{bankOneNext & oeOsc}};   // R04
         bankTwoOutputs   <= {BANK_WIDTH{bankTwoNext & oeOsc}};   // R04
         bankThreeOutputs <= {BANK_WIDTH{bankThreeNext & oeOsc}}; // R04
         bankFourOutputs  <= {BANK_WIDTH{bankFourNext & oeOsc}};  // R04
         pllBypass        <= testOsc; // R06 R14
      end
   end
endmodule

/* File: test/pcbd_checker.sv */
// port-level assertions for the clock bank divider
module pcbd_checker
   import pcbd_pkg::*;
(
   input wire logic                  mclk,
   input wire logic                  resetn,
   input wire logic                  oscClk,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic [BANK_WIDTH-1:0] bankOneOutputs,
   input wire logic [BANK_WIDTH-1:0] bankTwoOutputs,
   input wire logic [BANK_WIDTH-1:0] bankThreeOutputs,
   input wire logic [BANK_WIDTH-1:0] bankFourOutputs
);
   // both channels taken together: held next edge, answer the edge after
   a_write_answer: assert property (
      @(posedge mclk) disable iff (!resetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property (
      @(posedge mclk) disable iff (!resetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_busy_write: assert property (
      @(posedge mclk) disable iff (!resetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_busy_read: assert property (
      @(posedge mclk) disable iff (!resetn)
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_bits_equal: assert property (
      @(posedge oscClk) disable iff (!resetn)
      (&bankOneOutputs) == (|bankOneOutputs)
      && (&bankTwoOutputs) == (|bankTwoOutputs)
      && (&bankThreeOutputs) == (|bankThreeOutputs)
      && (&bankFourOutputs) == (|bankFourOutputs))
      else $error("bank bits differ");
   a_half_toggle: assert property (
      @(posedge oscClk) disable iff (!resetn)
      bankFourOutputs[0] |=> !bankFourOutputs[0]) else $error("half stuck");
   a_three_quarter: assert property (
      @(posedge oscClk) disable iff (!resetn)
      bankThreeOutputs != bankFourOutputs
      |-> bankTwoOutputs == bankThreeOutputs
      && bankOneOutputs == bankThreeOutputs) else $error("bank order bad");
   a_two_quarter: assert property (
      @(posedge oscClk) disable iff (!resetn)
      bankTwoOutputs != bankFourOutputs |-> bankOneOutputs == bankTwoOutputs)
      else $error("quarter banks unaligned");
endmodule
bind pcbd_top pcbd_checker chk_u (.*);

/* File: test/pcbd_ref_source.sv */
// reference clock source and the feedback loop wiring
module pcbd_ref_source
   import pcbd_pkg::*;
(
   input  wire logic fbTap,
   output logic      refClk,
   output logic      fbOut
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      refClk = 1'b0;
      forever #6 refClk = ~refClk;
   end
   assign fbOut = fbTap;
endmodule

/* File: test/pll_clock_bank_divider_tb.sv */
// self-checking bench for the clock bank divider
module pll_clock_bank_divider_tb
   import pcbd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
      n_mismatch++; $display("BAD %0t got %0h want %0h", $time, a, e); end end
   logic mclk, resetn, oscClk, diffReferenceClock, loopFeedbackInput;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, pllBypass;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [BANK_WIDTH-1:0] bankOneOutputs, bankTwoOutputs;
   logic [BANK_WIDTH-1:0] bankThreeOutputs, bankFourOutputs;
   int n_mismatch, total_checks;
   int t[4];
   wire [3:0] lsbs = {bankFourOutputs[0], bankThreeOutputs[0],
                      bankTwoOutputs[0], bankOneOutputs[0]};
   pcbd_top dut_u (.*);
   pcbd_ref_source ref_u (.fbTap(bankFourOutputs[0]),
      .refClk(diffReferenceClock), .fbOut(loopFeedbackInput));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      oscClk = 1'b0;
      #1.7;
      forever #3 oscClk = ~oscClk;
   end
   task automatic conclude();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, w, input logic [3:0] s);
      @(posedge mclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_wstrb <= s;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge mclk);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= a;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // count toggles of each bank over eight oscillator cycles
   task automatic meas();
      logic [3:0] p, c;
      t = '{default: 0};
      @(posedge mclk);
      @(negedge oscClk);
      p = lsbs;
      repeat (8) begin
         @(negedge oscClk);
         c = lsbs;
         for (int i = 0; i < 4; i++) t[i] += int'(c[i] != p[i]);
         p = c;
      end
   endtask
   initial begin
      #100us;
      n_mismatch++;
      conclude();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, resetn} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'h0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      rd(CONFIG_OFFSET);
      `CHK(d, CONFIG_RESET)
      `CHK({bankOneOutputs, bankFourOutputs}, 6'h00)
      for (int s = 0; s < 4; s++) begin
         wr(CONFIG_OFFSET, 32'h0000_0010 | s, 4'hf);
         meas();
         for (int b = 0; b < 4; b++) `CHK(t[b], (b < s) ? 4 : 8)
      end
      wr(CONFIG_OFFSET, 32'h0000_0003, 4'hf);
      meas();
      // clear held low must not stop the dividers
      `CHK(t[3], 8)
      `CHK(t[0], 4)
      rd(STATUS_OFFSET);
      // feedback is the registered half rate: opposite phase
      `CHK({d[31:4], d[3] ^ d[0]}, {28'h000_0000, 1'b1})
      wr(CONFIG_OFFSET, 32'h0000_0013, 4'hf);
      meas();
      `CHK(t[2] * 2 + t[3], 16)
      wr(CONFIG_OFFSET, 32'h0000_001b, 4'hf);
      meas();
      `CHK(pllBypass, 1'b1)
      wr(CONFIG_OFFSET, 32'h0000_0017, 4'h1);
      meas();
      `CHK(pllBypass + t[0] + t[3], 0)
      `CHK({bankOneOutputs, bankFourOutputs}, 6'h00)
      wr(CONFIG_OFFSET, 32'h0000_0000, 4'h0);
      wr(STATUS_OFFSET, 32'h0000_0000, 4'hf);
      `CHK(r, RESP_OKAY)
      rd(CONFIG_OFFSET);
      `CHK(d, 32'h0000_0017)
      wr(32'h0000_0008, 32'h0000_0001, 4'hf);
      `CHK(r, RESP_SLVERR)
      rd(32'h0000_0008);
      `CHK({d, r}, {32'h0000_0000, RESP_SLVERR})
      conclude();
   end
endmodule
